// file: hw/fhlm_monitor.sv
// fhlm_monitor.sv: five fan hour counters with lifetime alarm behind AXI4-Lite
// assumes fan commands and speeds from logic on aclk; the rating strap is a pin
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fhlm_regs.svh"

module fhlm_monitor
#(
   parameter fhlm_pkg::fhlm_pre_t HOUR_CYCLES = fhlm_pkg::fhlm_pre_t'(`FHLM_HOUR_CYC)
)
(
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [`FHLM_ADDR_W-1:0]      awaddr,
   input  wire logic [2:0]                   awprot,
   input  wire logic                         awvalid,
   output logic                              awready,
   input  wire logic [31:0]                  wdata,
   input  wire logic [3:0]                   wstrb,
   input  wire logic                         wvalid,
   output logic                              wready,
   output logic [1:0]                        bresp,
   output logic                              bvalid,
   input  wire logic                         bready,
   input  wire logic [`FHLM_ADDR_W-1:0]      araddr,
   input  wire logic [2:0]                   arprot,
   input  wire logic                         arvalid,
   output logic                              arready,
   output logic [31:0]                       rdata,
   output logic [1:0]                        rresp,
   output logic                              rvalid,
   input  wire logic                         rready,
   input  wire logic [`FHLM_NINT-1:0]        fan_on,
   input  wire logic [`FHLM_NINT-1:0][15:0]  fan_speed,
   input  wire logic [15:0]                  unit_rated_amps,
   output logic                              external_fan_drive,
   output logic [1:0]                        fan_type_indicator,
   output logic [`FHLM_NCH-1:0]              fan_lifetime_alarm,
   output logic                              irq
);
   localparam int NCH  = `FHLM_NCH;
   localparam int NINT = `FHLM_NINT;

   if (NCH != NINT + 1) $error("external fan must be the last channel");

   logic [31:0]                            ctrl;
   logic [15:0]                            thresh;
   logic [NCH-1:0][`FHLM_HOURS_W-1:0]      life;
   logic [NCH-1:0]                         irq_st;
   logic [NCH-1:0]                         irq_en;
   logic [NCH-1:0]                         alarm_q;
   logic [NCH-1:0]                         hclr;
   logic [NCH-1:0]                         irq_clr;
   logic [NCH-1:0]                         fitted;
   logic [NCH-1:0]                         run_vec;
   logic [15:0]                            amps_s;
   fhlm_pkg::fhlm_fan_type_t               fan_type;
   fhlm_pkg::fhlm_chan_ctl_t  [NCH-1:0]    ctl;
   fhlm_pkg::fhlm_chan_stat_t [NCH-1:0]    stat;
   logic                                   aw_held;
   logic                                   w_held;
   logic [`FHLM_ADDR_W-1:0]                wr_addr;
   logic [31:0]                            wr_data;
   logic [3:0]                             wr_strb;
   logic                                   wr_go;
   logic                                   wr_ok;
   logic [31:0]                            wr_bits;
   logic [31:0]                            rd_word;
   logic                                   rd_ok;
   logic [31:0]                            status_word;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
            r[8*b +: 8] = d[8*b +: 8];
      end
      return r;
   endfunction

   function automatic logic [`FHLM_ADDR_W-1:0] hours_addr(input int i);
      return `FHLM_ADDR_W'(`FHLM_HOURS_BASE + 4 * i);
   endfunction

   function automatic logic [`FHLM_ADDR_W-1:0] life_addr(input int i);
      return `FHLM_ADDR_W'(`FHLM_LIFE_BASE + 4 * i);
   endfunction

   // strict greater: a fan just at 5 % counts as stopped
   function automatic logic speed_ok(input logic [15:0] spd, input logic [15:0] thr);
      return (24'(spd) * `FHLM_PCT_FULL) > (24'(thr) * `FHLM_SPEED_PCT);
   endfunction

   function automatic fhlm_pkg::fhlm_fan_type_t classify(input logic [15:0] a);
      if (a < `FHLM_FAN_MIN_A)
         return fhlm_pkg::fhlm_fan_none;
      else if (a < `FHLM_LINE_FAN_A)
         return fhlm_pkg::fhlm_fan_internal;
      else
         return fhlm_pkg::fhlm_fan_line;
   endfunction

   function automatic logic [NINT-1:0] fit_int(input fhlm_pkg::fhlm_fan_type_t t);
      case (t)
         fhlm_pkg::fhlm_fan_internal: return `FHLM_FIT_INT;
         fhlm_pkg::fhlm_fan_line:     return `FHLM_FIT_LINE;
         default:                     return '0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // fan arrangement from the rating strap
   fhlm_sync #(
      .W       (16)
   ) u_amps (
      .aclk_d  (unit_rated_amps),
      .aclk    (aclk),
      .aresetn (aresetn),
      .q       (amps_s)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fan_type <= fhlm_pkg::fhlm_fan_none;
      else
         fan_type <= classify(amps_s);
   end

   assign fan_type_indicator = fan_type;
   assign external_fan_drive = ctrl[`FHLM_CTRL_DRV];
   assign fitted = {ctrl[`FHLM_CTRL_FIT], fit_int(fan_type)};

   ////////////////////////////////////////////////////////////////////////////
   // channels
   always_comb
   begin
      for (int i = 0; i < NINT; i++)
         run_vec[i] = fitted[i] && fan_on[i] && speed_ok(fan_speed[i], thresh);
      run_vec[NCH-1] = fitted[NCH-1] && ctrl[`FHLM_CTRL_DRV];
   end

   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      assign ctl[i].run      = run_vec[i];
      assign ctl[i].clear    = hclr[i];
      assign ctl[i].lifetime = life[i];
      assign fan_lifetime_alarm[i] = stat[i].alarm;

      fhlm_chan #(
         .HOUR_CYCLES (HOUR_CYCLES)
      ) u_chan (
         .aclk        (aclk),
         .aresetn     (aresetn),
         .ctl         (ctl[i]),
         .stat        (stat[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   assign awready = !aw_held && !bvalid;
   assign wready  = !w_held && !bvalid;
   assign wr_go   = aw_held && w_held && !bvalid;
   assign wr_bits = merge(32'h0000_0000, wr_data, wr_strb);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         wr_addr <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_held <= 1'b1;
         wr_addr <= awaddr;
      end
      else if (wr_go)
         aw_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held  <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end
      else if (wvalid && wready)
      begin
         w_held  <= 1'b1;
         wr_data <= wdata;
         wr_strb <= wstrb;
      end
      else if (wr_go)
         w_held <= 1'b0;
   end

   always_comb
   begin
      wr_ok = 1'b0;
      case (wr_addr)
         `FHLM_CTRL, `FHLM_STATUS, `FHLM_THRESH, `FHLM_HCLR,
         `FHLM_IRQ_ST, `FHLM_IRQ_CLR, `FHLM_IRQ_EN, `FHLM_ALARM:
            wr_ok = 1'b1;
         default:
         begin
            for (int i = 0; i < NCH; i++)
            begin
               if (wr_addr == hours_addr(i) || wr_addr == life_addr(i))
                  wr_ok = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= 2'h0;
      end
      else if (wr_go)
      begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // writable registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl <= `FHLM_CTRL_RST;
      else if (wr_go && wr_addr == `FHLM_CTRL)
         ctrl <= merge(ctrl, wr_data, wr_strb) & 32'h0000_0003;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         thresh <= `FHLM_THRESH_RST;
      else if (wr_go && wr_addr == `FHLM_THRESH)
         thresh <= 16'(merge({16'h0000, thresh}, wr_data, wr_strb));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_en <= '0;
      else if (wr_go && wr_addr == `FHLM_IRQ_EN)
         irq_en <= NCH'(merge(32'(irq_en), wr_data, wr_strb));
   end

   // defaults reload on reset
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < NCH; i++)
      begin
         if (!aresetn)
            life[i] <= `FHLM_LIFE_RST;
         else if (wr_go && wr_addr == life_addr(i))
            life[i] <= merge(life[i], wr_data, wr_strb);
      end
   end

   // write-one pulses, the counter itself is cleared inside the channel
   assign hclr    = (wr_go && wr_addr == `FHLM_HCLR) ? wr_bits[NCH-1:0] : '0;
   assign irq_clr = (wr_go && wr_addr == `FHLM_IRQ_CLR) ? wr_bits[NCH-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: alarm rise is the event; set wins over a same-cycle clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         alarm_q <= '0;
         irq_st  <= '0;
      end
      else
      begin
         alarm_q <= fan_lifetime_alarm;
         irq_st  <= (irq_st & ~irq_clr) | (fan_lifetime_alarm & ~alarm_q);
      end
   end

   assign irq = |(irq_st & irq_en);

   ////////////////////////////////////////////////////////////////////////////
   // read channel, one cycle to rvalid
   assign arready = !rvalid;

   always_comb
   begin
      status_word = '0;
      status_word[`FHLM_ST_TYPE +: 2]   = fan_type;
      status_word[`FHLM_ST_FIT +: NCH]  = fitted;
      status_word[`FHLM_ST_RUN +: NCH]  = run_vec;
   end

   always_comb
   begin
      rd_word = '0;
      rd_ok   = 1'b1;
      case (araddr)
         `FHLM_CTRL:   rd_word = ctrl;
         `FHLM_STATUS: rd_word = status_word;
         `FHLM_THRESH: rd_word = {16'h0000, thresh};
         `FHLM_IRQ_ST: rd_word = 32'(irq_st);
         `FHLM_IRQ_EN: rd_word = 32'(irq_en);
         `FHLM_ALARM:  rd_word = 32'(fan_lifetime_alarm);
         `FHLM_HCLR, `FHLM_IRQ_CLR:
            rd_word = '0;
         default:
         begin
            rd_ok = 1'b0;
            for (int i = 0; i < NCH; i++)
            begin
               if (araddr == hours_addr(i))
               begin
                  rd_word = stat[i].hours;
                  rd_ok   = 1'b1;
               end
               if (araddr == life_addr(i))
               begin
                  rd_word = life[i];
                  rd_ok   = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= 2'h0;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata  <= rd_word;
         rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_speed_gate;
      $changed(stat[0].hours) && !$past(hclr[0])
         |-> $past(fan_on[0] && fitted[0] && speed_ok(fan_speed[0], thresh));
   endproperty
   property p_ext_count;
      $changed(stat[NCH-1].hours) && !$past(hclr[NCH-1]) |-> $past(external_fan_drive);
   endproperty
   property p_unfit;
      !fitted[1] && !hclr[1] |=> $stable(stat[1].hours);
   endproperty
   property p_type;
      $stable(unit_rated_amps) [*5] |-> fan_type_indicator == classify(unit_rated_amps);
   endproperty
   property p_life_rst;
      $rose(aresetn) |-> life == {NCH{`FHLM_LIFE_RST}};
   endproperty
   property p_irq;
      $rose(fan_lifetime_alarm[0]) && irq_en[0] |=> irq;
   endproperty
   property p_five;
      $rose(fan_lifetime_alarm[NCH-1]) |=> irq_st[NCH-1];
   endproperty
   property p_bhold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty

   a_speed_gate: assert property (p_speed_gate) else $error("fan counted without speed");
   a_ext_count: assert property (p_ext_count) else $error("external fan counted undriven");
   a_unfit: assert property (p_unfit) else $error("unfitted fan counter moved");
   a_type: assert property (p_type) else $error("fan arrangement mismatch");
   a_life_rst: assert property (p_life_rst) else $error("lifetime default wrong");
   a_irq: assert property (p_irq) else $error("alarm rise gave no interrupt");
   a_five: assert property (p_five) else $error("external channel event lost");
   a_bhold: assert property (p_bhold) else $error("write response dropped early");
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (rvalid && rresp == 2'h2);
   c_clear: cover property (|hclr);
endmodule

`default_nettype wire

// file: hw/fhlm_regs.svh
// fhlm_regs.svh: offsets, field positions, reset values and timing of the fan hours monitor
// assumes a 100 MHz aclk and 32-bit AXI4-Lite words on byte addresses
// Function
// - five hour counters: 0 to 3 internal connector fans, 4 the external fan
// - count only while commanded on and speed above 5 % of monitor threshold
// - external fan channel 4 ignores speed, counts while commanded on
// - channels of fans not fitted never count
// - each channel has a planned lifetime, 30000 hours after defaults load
// - alarm once counted hours reach planned lifetime minus 500 hours
// - planned lifetime zero disables supervision and alarm of that channel
// - writing 1 to a channel clear bit zeroes its counter; do at replacement
// - report fans: none below 210 A, two internal below 400 A, else line fan
`ifndef FHLM_REGS_SVH
`define FHLM_REGS_SVH

`define FHLM_NCH         5
`define FHLM_NINT        4
`define FHLM_HOURS_W     32
`define FHLM_PRE_W       40
`define FHLM_ADDR_W      8

`define FHLM_CTRL        8'h00
`define FHLM_STATUS      8'h04
`define FHLM_THRESH      8'h08
`define FHLM_HCLR        8'h0C
`define FHLM_IRQ_ST      8'h10
`define FHLM_IRQ_CLR     8'h14
`define FHLM_IRQ_EN      8'h18
`define FHLM_ALARM       8'h1C
`define FHLM_HOURS_BASE  8'h20
`define FHLM_LIFE_BASE   8'h40

`define FHLM_CTRL_DRV    0
`define FHLM_CTRL_FIT    1
`define FHLM_ST_TYPE     0
`define FHLM_ST_FIT      8
`define FHLM_ST_RUN      16

`define FHLM_CTRL_RST    32'h0000_0000
`define FHLM_THRESH_RST  16'h0000
`define FHLM_LIFE_RST    32'h0000_7530
`define FHLM_WARN_HOURS  33'h0_0000_01F4
`define FHLM_SPEED_PCT   24'h00_0005
`define FHLM_PCT_FULL    24'h00_0064
`define FHLM_FAN_MIN_A   16'h00D2
`define FHLM_LINE_FAN_A  16'h0190
`define FHLM_FIT_INT     4'h3
`define FHLM_FIT_LINE    4'h1

`define FHLM_HOUR_S      64'h0000_0000_0000_0E10
`define FHLM_CLK_HZ      64'h0000_0000_05F5_E100
`define FHLM_HOUR_CYC    (`FHLM_HOUR_S * `FHLM_CLK_HZ)

`endif

// file: hw/fhlm_pkg.sv
// fhlm_pkg.sv: types shared by the fan hours monitor modules
// assumes fhlm_regs.svh on the include path
`default_nettype none
`include "fhlm_regs.svh"

package fhlm_pkg;
   typedef logic [`FHLM_PRE_W-1:0] fhlm_pre_t;
   typedef enum logic [1:0] {
      fhlm_fan_none     = 2'h0,
      fhlm_fan_internal = 2'h1,
      fhlm_fan_line     = 2'h3
   } fhlm_fan_type_t;
   typedef struct packed {
      logic                     run;
      logic                     clear;
      logic [`FHLM_HOURS_W-1:0] lifetime;
   } fhlm_chan_ctl_t;
   typedef struct packed {
      logic [`FHLM_HOURS_W-1:0] hours;
      logic                     alarm;
   } fhlm_chan_stat_t;
endpackage

`default_nettype wire

// file: hw/fhlm_sync.sv
// fhlm_sync.sv: two-flop synchroniser for slow pin levels
// assumes inputs change rarely; a multi-bit value may skew for one cycle
`timescale 1ns/1ps
`default_nettype none

module fhlm_sync
#(
   parameter int W = 16
)
(
   input  wire logic [W-1:0] aclk_d,
   input  wire logic         aclk,
   input  wire logic         aresetn,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   if (W < 1) $error("sync width must be positive");

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= aclk_d;
         q    <= meta;
      end
   end
endmodule

`default_nettype wire

// file: hw/fhlm_chan.sv
// fhlm_chan.sv: one fan channel: hour prescaler, hours counter, lifetime alarm
// assumes run and clear come from logic on aclk
`timescale 1ns/1ps
`default_nettype none
`include "fhlm_regs.svh"

module fhlm_chan
#(
   parameter fhlm_pkg::fhlm_pre_t HOUR_CYCLES = fhlm_pkg::fhlm_pre_t'(`FHLM_HOUR_CYC)
)
(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire fhlm_pkg::fhlm_chan_ctl_t  ctl,
   output var  fhlm_pkg::fhlm_chan_stat_t stat
);
   fhlm_pkg::fhlm_pre_t    pre;
   logic                   tick;
   logic [`FHLM_HOURS_W:0] reach;

   if (HOUR_CYCLES == '0) $error("hour prescale must be nonzero");

   assign tick  = ctl.run && (pre == HOUR_CYCLES - 1'b1);
   assign reach = {1'b0, stat.hours} + `FHLM_WARN_HOURS;

   // partial hour kept while the fan stands, lost only on clear or reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ctl.clear)
         pre <= '0;
      else if (tick)
         pre <= '0;
      else if (ctl.run)
         pre <= pre + 1'b1;
   end

   // clear beats a coinciding hour tick; saturates instead of wrapping
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ctl.clear)
         stat.hours <= '0;
      else if (tick && !(&stat.hours))
         stat.hours <= stat.hours + 1'b1;
   end

   // level alarm, so it drops by itself once hours fall below the point
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         stat.alarm <= 1'b0;
      else
         stat.alarm <= (ctl.lifetime != '0) && (reach >= {1'b0, ctl.lifetime});
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_step;
      $changed(stat.hours) && !$past(ctl.clear) |-> $past(ctl.run) && $past(pre) == HOUR_CYCLES - 1'b1;
   endproperty
   property p_hold;
      !ctl.run && !ctl.clear |=> $stable(pre) && $stable(stat.hours);
   endproperty
   property p_clear;
      ctl.clear |=> stat.hours == '0 && pre == '0;
   endproperty
   property p_off;
      ctl.lifetime == '0 |=> !stat.alarm;
   endproperty
   property p_drop;
      ctl.clear ##1 (ctl.lifetime > `FHLM_HOURS_W'(`FHLM_WARN_HOURS)) |=> !stat.alarm;
   endproperty

   a_step: assert property (p_step) else $error("hours moved without an hour tick");
   a_hold: assert property (p_hold) else $error("idle channel advanced");
   a_clear: assert property (p_clear) else $error("clear did not zero the channel");
   a_off: assert property (p_off) else $error("alarm with lifetime zero");
   a_drop: assert property (p_drop) else $error("alarm stayed after clear");
   c_tick: cover property (tick);
   c_alarm: cover property ($rose(stat.alarm));
endmodule

`default_nettype wire

// file: bench/fhlm_fan_model.sv
// fhlm_fan_model.sv: behavioural unit fans that report their measured speed
// assumes the bench sets each fan's nominal speed; spin up and down take one cycle
`timescale 1ns/1ps
`default_nettype none

module fhlm_fan_model
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [3:0]       fan_on,
   input  wire logic [3:0][15:0] rpm,
   output var  logic [3:0][15:0] fan_speed
);
   // a stopped fan reads zero, never its last speed
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         fan_speed[i] <= (aresetn && fan_on[i]) ? rpm[i] : 16'h0000;
      end
   end
endmodule
`default_nettype wire

// file: bench/fhlm_tb.sv
// fhlm_tb.sv: self-checking bench of the fan hours monitor
// assumes one hour shortened to 10 clocks; the fan model drives the speeds
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} fhlm_row_t;
   logic             aclk = 1'b0;
   logic             aresetn = 1'b0;
   logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
   logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic             arvalid = 1'b0, rready = 1'b0;
   logic [31:0]      wdata = 32'h0000_0000;
   logic [3:0]       fan_on = 4'h0;
   logic [3:0][15:0] rpm = {16'h0100, 16'h0100, 16'h0005, 16'h0006};
   logic [3:0][15:0] fan_speed;
   logic [15:0]      amps = 16'h012C;
   logic             awready, wready, bvalid, arready, rvalid, ext_drv, irq;
   logic [1:0]       bresp, rresp, ftype;
   logic [31:0]      rdata, d;
   logic [1:0]       r;
   logic [4:0]       alarm;
   int               n_fail = 0, checks = 0;
   fhlm_row_t rows [0:12] = '{'{8'h00, 32'h0, 2'h0}, '{8'h08, 32'h0, 2'h0},
      '{8'h18, 32'h0, 2'h0}, '{8'h1C, 32'h0, 2'h0}, '{8'h20, 32'h0, 2'h0},
      '{8'h30, 32'h0, 2'h0}, '{8'h40, 32'h0000_7530, 2'h0}, '{8'h44, 32'h0000_7530, 2'h0},
      '{8'h48, 32'h0000_7530, 2'h0}, '{8'h4C, 32'h0000_7530, 2'h0},
      '{8'h50, 32'h0000_7530, 2'h0}, '{8'h02, 32'h0, 2'h2}, '{8'hFC, 32'h0, 2'h2}};
   logic [31:0] hrs [0:4] = '{32'h3, 32'h0, 32'h0, 32'h0, 32'h2};
   logic [15:0] strap [0:3] = '{16'h00D2, 16'h00D1, 16'h018F, 16'h0190};
   logic [1:0]  stype [0:3] = '{2'h1, 2'h0, 2'h1, 2'h3};

   always #5 aclk = ~aclk;

   fhlm_fan_model i_fans (.aclk(aclk), .aresetn(aresetn), .fan_on(fan_on), .rpm(rpm),
      .fan_speed(fan_speed));

   fhlm_monitor #(.HOUR_CYCLES(40'h00_0000_000A)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .fan_on(fan_on), .fan_speed(fan_speed), .unit_rated_amps(amps),
      .external_fan_drive(ext_drv), .fan_type_indicator(ftype),
      .fan_lifetime_alarm(alarm), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // both channels offered together, each released once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // the requests just scheduled are not visible yet, so wait an edge first
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
         end
      end while (awvalid || wvalid || bready);
   endtask

   task automatic axr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end while (arvalid || rready);
   endtask

   // alarm is registered after the lifetime lands, so let it settle
   task automatic life0(input logic [31:0] v, input logic e);
      axw(8'h40, v);
      repeat (3) @(posedge aclk);
      chk("alarm0", {31'h0, e}, {31'h0, alarm[0]});
   endtask

   task automatic wrap_up();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      n_fail++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      foreach (rows[i])
      begin
         axr(rows[i].a);
         chk("rdata", rows[i].d, d);
         chk("rresp", {30'h0, rows[i].r}, {30'h0, r});
      end
      chk("fan type", 32'h1, {30'h0, ftype});
      axr(8'h04);
      chk("fitted", 32'h03, {27'h0, d[12:8]});
      axw(8'hFC, 32'h0000_0001);
      chk("bresp", 32'h2, {30'h0, r});
      axw(8'h08, 32'h0000_0064);
      // two partial runs must add up, a lost remainder gives two hours
      fan_on <= 4'hF;
      repeat (16) @(posedge aclk);
      fan_on <= 4'h0;
      repeat (4) @(posedge aclk);
      fan_on <= 4'hF;
      repeat (16) @(posedge aclk);
      fan_on <= 4'h0;
      axw(8'h00, 32'h0000_0003);
      chk("ext drive", 32'h1, {31'h0, ext_drv});
      repeat (22) @(posedge aclk);
      axw(8'h00, 32'h0000_0000);
      for (int i = 0; i < 5; i++)
      begin
         axr(8'h20 + 8'(4 * i));
         chk("hours", hrs[i], d);
      end
      axw(8'h18, 32'h0000_001F);
      life0(32'h0000_01F8, 1'b0);
      life0(32'h0000_01F7, 1'b1);
      chk("irq", 32'h1, {31'h0, irq});
      life0(32'h0000_01F8, 1'b0);
      chk("irq sticky", 32'h1, {31'h0, irq});
      axw(8'h14, 32'h0000_0001);
      chk("irq clr", 32'h0, {31'h0, irq});
      life0(32'h0000_0000, 1'b0);
      life0(32'h0000_01F7, 1'b1);
      axw(8'h0C, 32'h0000_0001);
      repeat (3) @(posedge aclk);
      chk("alarm clr", 32'h0, {31'h0, alarm[0]});
      axr(8'h20);
      chk("hours clr", 32'h0, d);
      // external channel holds 2 hours: lifetime 502 puts it on the alarm point
      axw(8'h50, 32'h0000_01F6);
      repeat (3) @(posedge aclk);
      chk("alarm4", 32'h1, {31'h0, alarm[4]});
      axr(8'h1C);
      chk("alarm reg", 32'h10, d);
      axr(8'h10);
      chk("irq st", 32'h11, d);
      foreach (strap[i])
      begin
         amps <= strap[i];
         repeat (5) @(posedge aclk);
         chk("strap type", {30'h0, stype[i]}, {30'h0, ftype});
      end
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      axr(8'h40);
      chk("life rst", 32'h0000_7530, d);
      wrap_up();
   end
endmodule
`default_nettype wire
